// ==== hdl/uhp_port.sv ====
// Host access port, register file, modem inputs and serial engine.
// Assumes host pins are synchronous to clk; receiver clock is sampled.
//
// Functional notes
// - Selected while both high selects high, low low
// - Selection completes when latched by low strobe
// - Low strobe captures register select and selects
// - Read drives bus on either read strobe
// - Write stores bus on either write strobe
// - Access bit clear: code0 data, code1 enables
// - Access bit set: codes 0/1 reach divisor
// - Codes 2-6 fixed registers, 7 selects none
// - Access bit is line control top bit
// - Master clear spares data and divisor registers
// - Master clear: serial marking, modem outputs high
// - Master clear: irq low, change bits cleared
// - Receiver timed by separate 16x clock
// - Bit4 send status, bit0 its change
// - Bit5 ready status, bit1 its change
// - Bit7 carrier status, bit3 its change
// - Bit6 ring status, bit2 on pin rise
// - Send, ready, carrier changes raise interrupt
// - Ring interrupts only on trailing edge
// - Status read or master clear withdraws interrupt
// - Data one is mark, zero is space
`timescale 1ns/1ns
module uhp_port
    import uhp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic master_clear,
    input wire logic select_high_a,
    input wire logic select_high_b,
    input wire logic select_low_n,
    input wire logic address_latch_strobe_n,
    input wire logic reg_select_0,
    input wire logic reg_select_1,
    input wire logic reg_select_2,
    input wire logic read_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe,
    input wire logic write_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic chip_select_out,
    output logic driver_disable,
    input wire logic rclk_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic baud_out,
    input wire logic clear_to_send_n,
    input wire logic set_ready_n,
    input wire logic ring_n,
    input wire logic carrier_detect_n,
    output logic terminal_ready_n,
    output logic request_to_send_n,
    output logic user_out1_n,
    output logic user_out2_n,
    output logic irq_out
);
    logic ctrl_rst;
    logic sel_now, sel_r;
    logic [2:0] addr_r;
    logic rd_lvl, wr_lvl, rd_prev_r, wr_prev_r, rd_go, wr_go;
    logic divisor_access_bit;
    logic [7:0] ier_r, lcr_r, mcr_r, dll_r, dlm_r, thr_r, rbr_r;
    logic [7:0] interrupt_source, line_state, modem_input_state, rd_mux;
    logic thr_full_r, thre_int_r, data_ready_r, overrun_r;
    logic [3:0] mod_q, mod_act, mod_prev_r, msr_delta_r, mod_chg;
    logic rclk_q, rclk_prev_r, rx_tick, rx_done;
    logic [7:0] rx_byte;
    logic [15:0] divisor, div_cnt_r;
    logic baud_tick, tx_load;
    uhp_ser_t tx_state_r;
    logic [3:0] tx_os_r;
    logic [2:0] tx_bit_r;
    logic [7:0] tx_shift_r;
    logic wr_data, wr_dll, wr_dlm, rd_rbr, rd_msr, rd_lsr, rd_iir;

    // Master clear resets control state but not data or divisor
    assign ctrl_rst = !resetn || master_clear;

    ////////////////////////////////////////////////////////////////////////
    // Host port: selection latch and strobes
    assign sel_now = select_high_a && select_high_b && !select_low_n;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_r <= 1'b0;
            addr_r <= UHP_SEL_NONE;
        end else if (!address_latch_strobe_n) begin
            sel_r <= sel_now;
            addr_r <= {reg_select_2, reg_select_1, reg_select_0};
        end
    end

    assign rd_lvl = sel_r && (read_strobe || !read_strobe_n);
    assign wr_lvl = sel_r && (write_strobe || !write_strobe_n);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end else begin
            rd_prev_r <= rd_lvl;
            wr_prev_r <= wr_lvl;
        end
    end

    // One access per strobe, taken on its leading edge
    assign rd_go = rd_lvl && !rd_prev_r;
    assign wr_go = wr_lvl && !wr_prev_r;
    assign divisor_access_bit = lcr_r[UHP_LCR_DIV];

    assign wr_data = wr_go && addr_r == UHP_SEL_DATA && !divisor_access_bit;
    assign wr_dll = wr_go && addr_r == UHP_SEL_DATA && divisor_access_bit;
    assign wr_dlm = wr_go && addr_r == UHP_SEL_IER && divisor_access_bit;
    assign rd_rbr = rd_go && addr_r == UHP_SEL_DATA && !divisor_access_bit;
    assign rd_msr = rd_go && addr_r == UHP_SEL_MSR;
    assign rd_lsr = rd_go && addr_r == UHP_SEL_LSR;
    assign rd_iir = rd_go && addr_r == UHP_SEL_IIR;

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            ier_r <= UHP_ZERO;
            lcr_r <= UHP_ZERO;
            mcr_r <= UHP_ZERO;
        end else if (wr_go) begin
            case (addr_r)
                UHP_SEL_IER: begin
                    if (!divisor_access_bit) begin
                        ier_r <= data_in & UHP_IER_MASK;
                    end
                end
                UHP_SEL_LCR: lcr_r <= data_in;
                UHP_SEL_MCR: mcr_r <= data_in & UHP_IER_MASK;
                default: ;
            endcase
        end
    end

    // Data and divisor registers survive master clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dll_r <= UHP_ZERO;
            dlm_r <= UHP_ZERO;
            thr_r <= UHP_ZERO;
            rbr_r <= UHP_ZERO;
        end else begin
            if (wr_dll) begin
                dll_r <= data_in;
            end
            if (wr_dlm) begin
                dlm_r <= data_in;
            end
            if (wr_data) begin
                thr_r <= data_in;
            end
            if (rx_done) begin
                rbr_r <= rx_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line status flags; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            thr_full_r <= 1'b0;
            thre_int_r <= 1'b0;
            data_ready_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (wr_data) begin
                thr_full_r <= 1'b1;
            end else if (tx_load) begin
                thr_full_r <= 1'b0;
            end
            if (tx_load) begin
                thre_int_r <= 1'b1;
            end else if (wr_data || (rd_iir && interrupt_source == UHP_IIR_THRE)) begin
                thre_int_r <= 1'b0;
            end
            if (rx_done) begin
                data_ready_r <= 1'b1;
            end else if (rd_rbr) begin
                data_ready_r <= 1'b0;
            end
            if (rx_done && data_ready_r) begin
                overrun_r <= 1'b1;
            end else if (rd_lsr) begin
                overrun_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modem inputs
    uhp_sync2 #(.W(4), .INIT(UHP_MOD_IDLE)) mod_sync (
        .clk(clk),
        .resetn(resetn),
        .d({carrier_detect_n, ring_n, set_ready_n, clear_to_send_n}),
        .q(mod_q)
    );

    // Status bits read the active (low) pin condition as one
    assign mod_act = ~mod_q;
    assign mod_chg = {mod_prev_r[3] ^ mod_act[3],
                      mod_prev_r[UHP_MOD_RING] && !mod_act[UHP_MOD_RING],
                      mod_prev_r[1:0] ^ mod_act[1:0]};

    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            mod_prev_r <= mod_act;
            msr_delta_r <= '0;
        end else begin
            mod_prev_r <= mod_act;
            // New changes win over the clearing read
            msr_delta_r <= (rd_msr ? '0 : msr_delta_r) | mod_chg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, interrupt source and read data
    assign line_state = {1'b0, !thr_full_r && tx_state_r == UHP_IDLE, !thr_full_r,
                  3'h0, overrun_r, data_ready_r};
    assign modem_input_state = {mod_act, msr_delta_r};

    always_comb begin
        if (ier_r[UHP_IER_LINE] && overrun_r) begin
            interrupt_source = UHP_IIR_LINE;
        end else if (ier_r[UHP_IER_RX] && data_ready_r) begin
            interrupt_source = UHP_IIR_RX;
        end else if (ier_r[UHP_IER_THRE] && thre_int_r) begin
            interrupt_source = UHP_IIR_THRE;
        end else if (ier_r[UHP_IER_MODEM] && |msr_delta_r) begin
            interrupt_source = UHP_IIR_MODEM;
        end else begin
            interrupt_source = UHP_IIR_NONE;
        end
    end

    always_comb begin
        case (addr_r)
            UHP_SEL_DATA: rd_mux = divisor_access_bit ? dll_r : rbr_r;
            UHP_SEL_IER: rd_mux = divisor_access_bit ? dlm_r : ier_r;
            UHP_SEL_IIR: rd_mux = interrupt_source;
            UHP_SEL_LCR: rd_mux = lcr_r;
            UHP_SEL_MCR: rd_mux = mcr_r;
            UHP_SEL_LSR: rd_mux = line_state;
            UHP_SEL_MSR: rd_mux = modem_input_state;
            default: rd_mux = UHP_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out <= UHP_ZERO;
            data_oe <= 1'b0;
            driver_disable <= 1'b1;
            chip_select_out <= 1'b0;
        end else begin
            data_out <= rd_lvl ? rd_mux : UHP_ZERO;
            data_oe <= rd_lvl;
            driver_disable <= !rd_lvl;
            chip_select_out <= sel_r;
        end
    end

    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            irq_out <= 1'b0;
            terminal_ready_n <= 1'b1;
            request_to_send_n <= 1'b1;
            user_out1_n <= 1'b1;
            user_out2_n <= 1'b1;
        end else begin
            irq_out <= interrupt_source != UHP_IIR_NONE;
            terminal_ready_n <= !mcr_r[UHP_MCR_DTR];
            request_to_send_n <= !mcr_r[UHP_MCR_RTS];
            user_out1_n <= !mcr_r[UHP_MCR_OUT1];
            user_out2_n <= !mcr_r[UHP_MCR_OUT2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver on the sampled receiver clock
    uhp_sync2 #(.W(1), .INIT(1'b0)) rclk_sync (
        .clk(clk),
        .resetn(resetn),
        .d(rclk_in),
        .q(rclk_q)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rclk_prev_r <= 1'b0;
        end else begin
            rclk_prev_r <= rclk_q;
        end
    end

    assign rx_tick = rclk_q && !rclk_prev_r;

    uhp_rx rx (
        .clk(clk),
        .rst_n(!ctrl_rst),
        .tick(rx_tick),
        .serial_in(serial_in),
        .rx_byte(rx_byte),
        .rx_done(rx_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Baud generator and transmitter
    assign divisor = {dlm_r, dll_r};
    assign baud_tick = divisor != 16'h0000 && div_cnt_r == divisor - 16'h0001;
    assign tx_load = tx_state_r == UHP_IDLE && thr_full_r;

    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            div_cnt_r <= 16'h0000;
            baud_out <= 1'b0;
        end else begin
            div_cnt_r <= baud_tick ? 16'h0000 : div_cnt_r + 16'h0001;
            baud_out <= baud_tick;
        end
    end

    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            tx_state_r <= UHP_IDLE;
            tx_os_r <= '0;
            tx_bit_r <= '0;
            tx_shift_r <= UHP_ZERO;
        end else begin
            if (baud_tick) begin
                tx_os_r <= tx_os_r + 4'h1;
            end
            case (tx_state_r)
                UHP_IDLE: begin
                    tx_os_r <= '0;
                    if (tx_load) begin
                        tx_shift_r <= thr_r;
                        tx_state_r <= UHP_START;
                    end
                end
                UHP_START: begin
                    if (baud_tick && tx_os_r == UHP_OS_LAST) begin
                        tx_bit_r <= '0;
                        tx_state_r <= UHP_DATA;
                    end
                end
                UHP_DATA: begin
                    if (baud_tick && tx_os_r == UHP_OS_LAST) begin
                        tx_shift_r <= tx_shift_r >> 1;
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == UHP_BIT_LAST) begin
                            tx_state_r <= UHP_STOP;
                        end
                    end
                end
                UHP_STOP: begin
                    if (baud_tick && tx_os_r == UHP_OS_LAST) begin
                        tx_state_r <= UHP_IDLE;
                    end
                end
                default: tx_state_r <= UHP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (ctrl_rst) begin
            serial_out <= 1'b1;
        end else if (lcr_r[UHP_LCR_BREAK]) begin
            serial_out <= 1'b0;
        end else begin
            case (tx_state_r)
                UHP_START: serial_out <= 1'b0;
                UHP_DATA: serial_out <= tx_shift_r[0];
                default: serial_out <= 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_send_moves;
        $changed(clear_to_send_n) ##0 (!master_clear && !rd_msr) [*4];
    endsequence

    sequence s_start_bit;
        tx_state_r == UHP_START && !master_clear && !lcr_r[UHP_LCR_BREAK];
    endsequence

    sel_latch_a: assert property (!address_latch_strobe_n |=>
        sel_r == $past(sel_now)) else $error("selection not latched");
    sel_hold_a: assert property (address_latch_strobe_n |=>
        $stable(sel_r) && $stable(addr_r)) else $error("latch moved");
    read_drive_a: assert property (rd_lvl |=>
        data_oe && !driver_disable) else $error("read not driven");
    ier_write_a: assert property (wr_go && addr_r == UHP_SEL_IER
        && !divisor_access_bit && !master_clear |=> ier_r == ($past(data_in) & UHP_IER_MASK))
        else $error("enable write lost");
    div_write_a: assert property (wr_dll |=> dll_r == $past(data_in)
        && $stable(thr_r)) else $error("divisor write wrong");
    none_read_a: assert property (rd_lvl && addr_r == UHP_SEL_NONE
        |=> data_out == UHP_ZERO) else $error("code seven read data");
    mclear_keep_a: assert property (master_clear |=> lcr_r == UHP_ZERO
        && $stable(dll_r) && serial_out && terminal_ready_n && user_out2_n)
        else $error("master clear effect wrong");
    mclear_irq_a: assert property (master_clear |=> !irq_out
        && msr_delta_r == 4'h0) else $error("irq after master clear");
    send_change_a: assert property (s_send_moves |->
        msr_delta_r[0]) else $error("send change missed");
    ring_edge_a: assert property ($rose(msr_delta_r[UHP_MOD_RING]) |->
        $past(mod_prev_r[UHP_MOD_RING]) && !$past(mod_act[UHP_MOD_RING]))
        else $error("ring change on wrong edge");
    modem_irq_a: assert property (|msr_delta_r && ier_r[UHP_IER_MODEM]
        && !master_clear |=> irq_out) else $error("modem irq missing");
    status_clear_a: assert property (rd_msr && mod_chg == 4'h0
        && !master_clear |=> msr_delta_r == 4'h0) else $error("not cleared");
    start_space_a: assert property (s_start_bit |=> !serial_out)
        else $error("start bit not spacing");
endmodule

// ==== inc/uhp_pkg.sv ====
// Shared constants and types of the serial element's host port block.
// Assumes one 25 MHz clock; host pins arrive synchronous to it, modem inputs and receiver clock are synchronised.
package uhp_pkg;
    // Register select codes
    localparam logic [2:0] UHP_SEL_DATA = 3'h0;
    localparam logic [2:0] UHP_SEL_IER = 3'h1;
    localparam logic [2:0] UHP_SEL_IIR = 3'h2;
    localparam logic [2:0] UHP_SEL_LCR = 3'h3;
    localparam logic [2:0] UHP_SEL_MCR = 3'h4;
    localparam logic [2:0] UHP_SEL_LSR = 3'h5;
    localparam logic [2:0] UHP_SEL_MSR = 3'h6;
    localparam logic [2:0] UHP_SEL_NONE = 3'h7;
    // Field positions
    localparam int UHP_LCR_DIV = 7;
    localparam int UHP_LCR_BREAK = 6;
    localparam int UHP_MCR_DTR = 0;
    localparam int UHP_MCR_RTS = 1;
    localparam int UHP_MCR_OUT1 = 2;
    localparam int UHP_MCR_OUT2 = 3;
    localparam int UHP_IER_RX = 0;
    localparam int UHP_IER_THRE = 1;
    localparam int UHP_IER_LINE = 2;
    localparam int UHP_IER_MODEM = 3;
    localparam int UHP_LSR_DR = 0;
    localparam int UHP_LSR_OE = 1;
    localparam int UHP_LSR_THRE = 5;
    localparam int UHP_LSR_TEMT = 6;
    // Modem inputs, in status bit order: send, ready, ring, carrier
    localparam int UHP_MOD_RING = 2;
    localparam logic [3:0] UHP_MOD_IDLE = 4'hF;
    // Reset values and masks
    localparam logic [7:0] UHP_ZERO = 8'h00;
    localparam logic [7:0] UHP_IER_MASK = 8'h0F;
    // Interrupt source codes
    localparam logic [7:0] UHP_IIR_NONE = 8'h01;
    localparam logic [7:0] UHP_IIR_LINE = 8'h06;
    localparam logic [7:0] UHP_IIR_RX = 8'h04;
    localparam logic [7:0] UHP_IIR_THRE = 8'h02;
    localparam logic [7:0] UHP_IIR_MODEM = 8'h00;
    // Sixteen clocks per bit, eight data bits
    localparam logic [3:0] UHP_OS_LAST = 4'hF;
    localparam logic [3:0] UHP_OS_MID = 4'h7;
    localparam logic [2:0] UHP_BIT_LAST = 3'h7;
    typedef enum logic [1:0] {UHP_IDLE, UHP_START, UHP_DATA, UHP_STOP} uhp_ser_t;
endpackage

// ==== hdl/uhp_sync2.sv ====
// Two-stage synchroniser for a group of levels.
// Assumes the levels change slowly against clk.
`timescale 1ns/1ns
module uhp_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== hdl/uhp_rx.sv ====
// Receiver shift logic, advanced only by receiver clock ticks.
// Assumes tick is a one-cycle pulse per 16x receiver clock edge.
`timescale 1ns/1ns
module uhp_rx
    import uhp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic serial_in,
    output logic [7:0] rx_byte,
    output logic rx_done
);
    uhp_ser_t state_r;
    logic [3:0] os_r;
    logic [2:0] bit_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= UHP_IDLE;
            os_r <= '0;
            bit_r <= '0;
            rx_byte <= UHP_ZERO;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                os_r <= os_r + 4'h1;
                case (state_r)
                    UHP_IDLE: begin
                        os_r <= '0;
                        if (!serial_in) begin
                            state_r <= UHP_START;
                        end
                    end
                    UHP_START: begin
                        if (os_r == UHP_OS_MID) begin
                            os_r <= '0;
                            bit_r <= '0;
                            // Line back at mark mid-bit: false start
                            state_r <= serial_in ? UHP_IDLE : UHP_DATA;
                        end
                    end
                    UHP_DATA: begin
                        if (os_r == UHP_OS_LAST) begin
                            rx_byte <= {serial_in, rx_byte[7:1]};
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == UHP_BIT_LAST) begin
                                state_r <= UHP_STOP;
                            end
                        end
                    end
                    UHP_STOP: begin
                        if (os_r == UHP_OS_LAST) begin
                            rx_done <= 1'b1;
                            state_r <= UHP_IDLE;
                        end
                    end
                    default: state_r <= UHP_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== tb/uhp_modem.sv ====
// Modem side model: control lines, idle line, receiver clock.
// Assumes the bench names the lines to assert, active high.
`timescale 1ns/1ns
module uhp_modem (
    input wire logic clk,
    input wire logic [3:0] assert_lines,
    output logic cts_n,
    output logic dsr_n,
    output logic ring_n,
    output logic dcd_n,
    output logic line_rx,
    output logic rclk
);
    logic [1:0] div_r = 2'h0;
    // Levels change off the sampling edge
    always @(negedge clk) begin
        {dcd_n, ring_n, dsr_n, cts_n} <= ~assert_lines;
        div_r <= div_r + 2'h1;
    end
    // Free running 16x receiver clock
    assign rclk = div_r[1];
    // Idle line at marking
    assign line_rx = 1'b1;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the host port block.
// Assumes uhp_port and the modem model are compiled alongside.
`timescale 1ns/1ns
module testbench
    import uhp_pkg::*;
;
    logic clk = 0, resetn = 0, mc = 0, sa = 1, sb = 1, sl = 0;
    logic ads_n = 1, rs = 0, rs_n = 1, ws = 0, ws_n = 1, oe_q = 0;
    logic [2:0] a = 0;
    logic [7:0] din = 0, dout, r0, r1;
    logic [3:0] lines = 0, mods;
    logic oe, so, irq, cts_n, dsr_n, ring_n, dcd_n, rxl, rck, dd;
    logic [7:0] exp_q[$];
    int bad_count = 0, samples_checked = 0, cyc = 0;
    always #20 clk = ~clk;
    uhp_port i_uhp_port (.clk(clk), .resetn(resetn), .master_clear(mc),
        .select_high_a(sa), .select_high_b(sb), .select_low_n(sl),
        .address_latch_strobe_n(ads_n), .reg_select_0(a[0]),
        .reg_select_1(a[1]), .reg_select_2(a[2]), .read_strobe(rs),
        .read_strobe_n(rs_n), .write_strobe(ws), .write_strobe_n(ws_n),
        .data_in(din), .data_out(dout), .data_oe(oe),
        .chip_select_out(), .driver_disable(dd), .rclk_in(rck),
        .serial_in(rxl), .serial_out(so), .baud_out(),
        .clear_to_send_n(cts_n), .set_ready_n(dsr_n), .ring_n(ring_n),
        .carrier_detect_n(dcd_n), .terminal_ready_n(mods[0]),
        .request_to_send_n(mods[1]), .user_out1_n(mods[2]),
        .user_out2_n(mods[3]), .irq_out(irq));
    uhp_modem i_uhp_modem (.clk(clk), .assert_lines(lines),
        .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n), .dcd_n(dcd_n),
        .line_rx(rxl), .rclk(rck));
    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] want,
                       input string what);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s: expected %h seen %h", what, want,
                     seen);
        end
    endtask
    task automatic pins(input logic [7:0] e);
        chk({2'b00, so, irq, mods}, e, "pins");
    endtask
    // One access; alt uses the inverted strobe, d is data or expected
    task automatic acc(input logic w, input logic alt,
                       input logic [2:0] ad, input logic [7:0] d);
        @(negedge clk);
        ads_n = 0;
        a = ad;
        din = d;
        @(negedge clk);
        ads_n = 1;
        if (!w)
            exp_q.push_back(d);
        if (w)
            {ws, ws_n, rs, rs_n} = {!alt, !alt, 2'b01};
        else
            {ws, ws_n, rs, rs_n} = {2'b01, !alt, !alt};
        repeat (2) @(negedge clk);
        {ws, ws_n, rs, rs_n} = 4'h5;
        @(negedge clk);
    endtask
    // Takes the oldest note as each read result appears
    always @(negedge clk) begin
        if (oe && !oe_q) begin
            chk(dout, exp_q.pop_front(), "data_out");
            chk({7'h00, dd}, 8'h00, "driver_disable");
        end
        oe_q <= oe;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic settle(input logic [3:0] l);
        lines = l;
        repeat (6) @(negedge clk);
    endtask
    initial begin
        r0 = $urandom(32'h33056CE6);
        repeat (8) @(negedge clk);
        resetn = 1;
        pins(8'h2F);
        acc(0, 0, UHP_SEL_MSR, 8'h00);
        acc(0, 1, UHP_SEL_IIR, UHP_IIR_NONE);
        acc(0, 0, UHP_SEL_NONE, 8'h00);
        $display("test reset done");
        r0 = $urandom;
        r1 = $urandom;
        acc(1, 1, UHP_SEL_IER, {r0[7:4], 4'h8});
        acc(0, 0, UHP_SEL_IER, 8'h08);
        acc(1, 0, UHP_SEL_MCR, 8'h0F);
        acc(0, 1, UHP_SEL_MCR, 8'h0F);
        pins(8'h20);
        acc(1, 0, UHP_SEL_LCR, 8'h80);
        acc(1, 0, UHP_SEL_DATA, r0);
        acc(1, 1, UHP_SEL_IER, r1);
        acc(0, 0, UHP_SEL_DATA, r0);
        acc(0, 1, UHP_SEL_IER, r1);
        acc(1, 0, UHP_SEL_LCR, 8'h03);
        sb = 0;
        acc(1, 0, UHP_SEL_IER, 8'h00);
        sb = 1;
        acc(0, 0, UHP_SEL_IER, 8'h08);
        $display("test registers done");
        settle(4'h1);
        pins(8'h30);
        acc(0, 0, UHP_SEL_MSR, 8'h11);
        pins(8'h20);
        acc(0, 0, UHP_SEL_MSR, 8'h10);
        settle(4'h5);
        pins(8'h20);
        acc(0, 0, UHP_SEL_MSR, 8'h50);
        settle(4'h1);
        pins(8'h30);
        acc(0, 0, UHP_SEL_MSR, 8'h14);
        settle(4'hB);
        pins(8'h30);
        acc(0, 0, UHP_SEL_MSR, 8'hBA);
        $display("test modem done");
        settle(4'hB);
        mc = 1;
        repeat (2) @(negedge clk);
        pins(8'h2F);
        mc = 0;
        acc(0, 0, UHP_SEL_IER, 8'h00);
        acc(0, 0, UHP_SEL_MSR, 8'hB0);
        acc(1, 0, UHP_SEL_LCR, 8'h80);
        acc(0, 1, UHP_SEL_DATA, r0);
        acc(1, 0, UHP_SEL_LCR, 8'h03);
        acc(1, 0, UHP_SEL_DATA, r1);
        pins(8'h0F);
        repeat (4) @(negedge clk);
        $display("test clear done");
        test_done();
    end
endmodule
